// ==== device_status_supply_monitor.sv ====
// Device status and supply monitor: summary flags, supply faults and response gating.
// Assumes monitor and DSP inputs are asynchronous pins; host requests are on CLK.
`include "device_summary_status_defs.svh"
// Overview of operation
// [RULE1] Channel zero flag ORs its DSP faults.
// [RULE2] Channel one flag ORs its DSP faults.
// [RULE3] Link flag ORs mismatch and oscillator faults.
// [RULE4] Memory thermal flag ORs six status bits.
// [RULE5] Supply flag ORs all seven supply faults.
// [RULE6] One timer reloads while any supply fault.
// [RULE7] Timer counts down per tick, holds zero.
// [RULE8] DSI3/SPI: silent, then one error response.
// [RULE9] DSI3/SPI clear on read/report after expiry.
// [RULE10] PSI5: suppress while timer runs, autoclear.
// [RULE11] I2C: silent until expiry, read clears.
// [RULE12] Disable set: suppress then autoclear DSI3/SPI.
// [RULE13] Test flag set in test mode.
// [RULE14] Reset flag cleared by read or report.
// [RULE15] Init flag after reset or config change.
// [RULE16] Buffer low fault sets and feeds timer.
// [RULE17] Bus input low fault sets, feeds timer.
// [RULE18] Buffer high fault sets and feeds timer.
// [RULE19] Status registers read-only in every mode.
// [RULE20] Recovery time is a configurable reload constant.
module device_status_supply_monitor
    import device_summary_status_pkg::*;
#(
    parameter int          TICK_CYCLES  = `TICK_CYCLES,
    parameter logic [15:0] RECOVERY     = `RECOVERY_TICKS,
    parameter int          VALID_CYCLES = `DATA_VALID_CYCLES
) (
    input  wire logic                     CLK,
    input  wire logic                     RESET,
    input  wire device_summary_status_pkg::status_in_s  STATUS_IN,
    input  wire device_summary_status_pkg::supply_mon_s SUPPLY_MON,
    input  wire logic                     TEST_MODE_ENTER,
    input  wire logic                     TEST_MODE_EXIT,
    input  wire logic                     SUPPLY_AUTOCLEAR_SELECT,
    input  wire device_summary_status_pkg::iface_e      INTERFACE_TYPE_SELECT,
    input  wire logic [7:0]               CHAN_USER_CONFIG_ONE,
    input  wire logic [7:0]               CHAN_USER_CONFIG_THREE,
    input  wire device_summary_status_pkg::host_req_s   HOST_REQ,
    output logic [7:0]                    RD_DATA,
    output logic                          RD_VALID,
    output logic                          RESPONSE_ENABLE,
    output logic                          SEND_ERROR_CODE,
    output logic [7:0]                    SUMMARY_STATUS,
    output logic [7:0]                    SUPPLY_STATUS
);
    import device_summary_status_pkg::*;

    status_in_s  st_meta_q;
    status_in_s  st_q;
    supply_mon_s mon_meta_q;
    supply_mon_s mon_q;
    logic [7:0]  supply_q;
    logic [7:0]  supply_d;
    logic        reset_flag_q;
    logic        test_q;
    logic        err_pending_q;
    logic        resp_q;
    logic        errcode_q;
    logic [7:0]  rd_data_q;
    logic        rd_valid_q;
    logic [7:0]  summary_q;
    logic        was_expired_q;
    logic        expired;
    logic        init_busy;

    function automatic logic is_psi5(input iface_e t);
        return (t == IF_PSI5_A) || (t == IF_PSI5_B);
    endfunction
    function automatic logic is_i2c(input iface_e t);
        return (t == IF_I2C_A) || (t == IF_I2C_B);
    endfunction

    // Monitor and DSP status pins are asynchronous, so both pass two flops first.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_meta_q  <= '0;
            st_q       <= '0;
            mon_meta_q <= '0;
            mon_q      <= '0;
        end else begin
            st_meta_q  <= STATUS_IN;
            st_q       <= st_meta_q;
            mon_meta_q <= SUPPLY_MON;
            mon_q      <= mon_meta_q;
        end
    end

    // [RULE16] [RULE17] [RULE18] Live supply faults.
    wire [7:0] fault_now = {mon_q.buffer_supply_low, mon_q.bus_input_low, mon_q.buffer_supply_high, 1'b0,
                            mon_q.analog_regulator_range_fault, mon_q.digital_regulator_range_fault,
                            mon_q.otp_regulator_range_fault, mon_q.perimeter_continuity_fault};
    wire       fault_any = (fault_now != 8'h00);

    recovery_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .RELOAD      (RECOVERY)
    ) u_timer (
        .clk           (CLK),
        .reset         (RESET),
        .fault_present (fault_any),
        .expired       (expired)
    );

    init_tracker #(
        .VALID_CYCLES (VALID_CYCLES)
    ) u_init (
        .clk       (CLK),
        .reset     (RESET),
        .cfg_one   (CHAN_USER_CONFIG_ONE),
        .cfg_three (CHAN_USER_CONFIG_THREE),
        .init_busy (init_busy)
    );

    wire psi5       = is_psi5(INTERFACE_TYPE_SELECT);
    wire i2c        = is_i2c(INTERFACE_TYPE_SELECT);
    wire dsi_spi    = !psi5 && !i2c;
    wire auto_clear = psi5 || (dsi_spi && SUPPLY_AUTOCLEAR_SELECT);
    wire rd_sum     = HOST_REQ.rd_strobe && (HOST_REQ.rd_addr == `SUMMARY_STATUS_ADDR);
    wire rd_sup     = HOST_REQ.rd_strobe && (HOST_REQ.rd_addr == `SUPPLY_STATUS_ADDR);
    wire supply_any = (supply_q != 8'h00);

    // [RULE9] [RULE11] Host clear after expiry.
    wire host_clear = !auto_clear && expired &&
                      (rd_sup || (dsi_spi && HOST_REQ.tx_report_supply && HOST_REQ.tx_done));
    // [RULE10] [RULE12] Automatic clear at expiry.
    wire auto_clr   = auto_clear && expired;
    // A fault that is still present sets the bit again, so set wins over clear.
    assign supply_d = ((host_clear || auto_clr) ? 8'h00 : supply_q) | fault_now;

    // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] Summary ORs.
    wire [7:0] summary = {|st_q.chan_zero_dsp_status, |st_q.chan_one_dsp_status, |st_q.link_fault_status,
                          |st_q.memory_thermal_status, supply_any, test_q, reset_flag_q, init_busy};

    // [RULE19] Read-only decode.
    wire [7:0] rd_mux = (HOST_REQ.rd_addr == `SUMMARY_STATUS_ADDR)   ? summary :
                        (HOST_REQ.rd_addr == `SUPPLY_STATUS_ADDR)    ? supply_q :
                        (HOST_REQ.rd_addr == `MEMTHERM_STATUS_ADDR)  ? {st_q.memory_thermal_status, 2'b00} :
                        (HOST_REQ.rd_addr == `LINKFAULT_STATUS_ADDR) ? {st_q.link_fault_status, 6'h00} :
                        8'h00;

    // [RULE8] [RULE10] [RULE11] [RULE12] Response gate.
    wire resp_d = !(supply_any && !expired) && !(auto_clear && supply_any);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            supply_q <= `SUPPLY_RESET_VALUE;
        end else begin
            supply_q <= supply_d;
        end
    end

    // [RULE14] Reset flag clear.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            reset_flag_q <= 1'b1;
        end else if (rd_sum || (HOST_REQ.tx_report_reset && HOST_REQ.tx_done)) begin
            reset_flag_q <= 1'b0;
        end
    end

    // [RULE13] Test flag, cleared only by reset or a test mode exit.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            test_q <= 1'b0;
        end else if (TEST_MODE_ENTER) begin
            test_q <= 1'b1;
        end else if (TEST_MODE_EXIT) begin
            test_q <= 1'b0;
        end
    end

    // [RULE8] One error-code response after expiry.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            was_expired_q <= 1'b1;
            err_pending_q <= 1'b0;
        end else begin
            was_expired_q <= expired;
            if (dsi_spi && !SUPPLY_AUTOCLEAR_SELECT && expired && !was_expired_q) begin
                err_pending_q <= 1'b1;
            end else if (HOST_REQ.tx_done) begin
                err_pending_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            resp_q     <= 1'b1;
            errcode_q  <= 1'b0;
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
            summary_q  <= 8'h03;
        end else begin
            summary_q  <= summary;
            resp_q     <= resp_d;
            errcode_q  <= err_pending_q && !HOST_REQ.tx_done;
            rd_data_q  <= HOST_REQ.rd_strobe ? rd_mux : rd_data_q;
            rd_valid_q <= HOST_REQ.rd_strobe;
        end
    end

    assign RD_DATA         = rd_data_q;
    assign RD_VALID        = rd_valid_q;
    assign RESPONSE_ENABLE = resp_q;
    assign SEND_ERROR_CODE = errcode_q;
    assign SUMMARY_STATUS  = summary_q;
    assign SUPPLY_STATUS   = supply_q;

    a_supply_summary: assert property (@(posedge CLK) disable iff (RESET) // RULE5
        summary[`SUM_SUPPLY_BIT] == supply_any) else $error("Supply summary mismatch.");
    a_chan_zero_or: assert property (@(posedge CLK) disable iff (RESET) // RULE1
        summary[`SUM_CH0_BIT] == (st_q.chan_zero_dsp_status != 4'h0)) else $error("Channel zero flag wrong.");
    a_chan_one_or: assert property (@(posedge CLK) disable iff (RESET) // RULE2
        summary[`SUM_CH1_BIT] == (st_q.chan_one_dsp_status != 4'h0)) else $error("Channel one flag wrong.");
    a_link_or: assert property (@(posedge CLK) disable iff (RESET) // RULE3
        summary[`SUM_LINK_BIT] == (st_q.link_fault_status != 2'h0)) else $error("Link flag wrong.");
    a_memt_or: assert property (@(posedge CLK) disable iff (RESET) // RULE4
        summary[`SUM_MEMT_BIT] == (st_q.memory_thermal_status != 6'h00)) else $error("Memory flag wrong.");
    a_fault_latches: assert property (@(posedge CLK) disable iff (RESET) // RULE16
        fault_now[`SUP_BUF_LOW_BIT] |=> supply_q[`SUP_BUF_LOW_BIT]) else $error("Buffer low not latched.");
    a_no_early_clear: assert property (@(posedge CLK) disable iff (RESET) // RULE9
        (supply_any && !expired && !fault_any) |=> supply_any) else $error("Supply cleared before expiry.");
    a_silent_running: assert property (@(posedge CLK) disable iff (RESET) // RULE10
        (supply_any && !expired) |=> !resp_q) else $error("Response while timer runs.");
    a_reset_flag_read: assert property (@(posedge CLK) disable iff (RESET) // RULE14
        rd_sum |=> !reset_flag_q) else $error("Reset flag not cleared by read.");
    a_test_sets: assert property (@(posedge CLK) disable iff (RESET) // RULE13
        TEST_MODE_ENTER |=> test_q) else $error("Test flag not set.");
endmodule

// ==== device_summary_status_defs.svh ====
// Offsets, field positions, reset values and timing counts for the device status block.
// Assumes a 10 MHz primary clock and a single synchronous reset domain.
`ifndef DEVICE_SUMMARY_STATUS_DEFS_SVH
`define DEVICE_SUMMARY_STATUS_DEFS_SVH

`define SUMMARY_STATUS_ADDR   8'h01
`define SUPPLY_STATUS_ADDR    8'h02
`define MEMTHERM_STATUS_ADDR  8'h03
`define LINKFAULT_STATUS_ADDR 8'h04

`define SUM_CH0_BIT     7
`define SUM_CH1_BIT     6
`define SUM_LINK_BIT    5
`define SUM_MEMT_BIT    4
`define SUM_SUPPLY_BIT  3
`define SUM_TEST_BIT    2
`define SUM_RESET_BIT   1
`define SUM_INIT_BIT    0

`define SUP_BUF_LOW_BIT   7
`define SUP_BUS_LOW_BIT   6
`define SUP_BUF_HIGH_BIT  5
`define SUP_ANA_REG_BIT   3
`define SUP_DIG_REG_BIT   2
`define SUP_OTP_REG_BIT   1
`define SUP_CONT_BIT      0

`define SUPPLY_RESET_VALUE 8'h00
`define CFG1_WATCH_MASK    8'hFC
`define CFG3_WATCH_MASK    8'h03

`define TICK_PERIOD_NS     100000
`define CLK_PERIOD_NS      100
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define RECOVERY_TICKS     16'h0014
`define DATA_VALID_US      1000
`define DATA_VALID_CYCLES  ((`DATA_VALID_US * 1000) / `CLK_PERIOD_NS)

`endif

// ==== device_summary_status_pkg.sv ====
// Types shared by the device status block.
// Assumes the constants header is included by each design file.
package device_summary_status_pkg;
    typedef enum logic [2:0] {
        IF_DSI3_A = 3'h0,
        IF_PSI5_A = 3'h1,
        IF_SPI_A  = 3'h2,
        IF_SPI_B  = 3'h3,
        IF_DSI3_B = 3'h4,
        IF_PSI5_B = 3'h5,
        IF_I2C_A  = 3'h6,
        IF_I2C_B  = 3'h7
    } iface_e;

    typedef struct packed {
        logic [3:0] chan_zero_dsp_status;
        logic [3:0] chan_one_dsp_status;
        logic [1:0] link_fault_status;
        logic [5:0] memory_thermal_status;
    } status_in_s;

    typedef struct packed {
        logic buffer_supply_low;
        logic bus_input_low;
        logic buffer_supply_high;
        logic analog_regulator_range_fault;
        logic digital_regulator_range_fault;
        logic otp_regulator_range_fault;
        logic perimeter_continuity_fault;
    } supply_mon_s;

    typedef struct packed {
        logic       rd_strobe;
        logic [7:0] rd_addr;
        logic       tx_report_supply;
        logic       tx_report_reset;
        logic       tx_done;
    } host_req_s;
endpackage

// ==== init_tracker.sv ====
// Tracks initialization after reset or a watched configuration change.
// Assumes configuration bytes come from registers on the same clock.
`include "device_summary_status_defs.svh"
module init_tracker #(
    parameter int VALID_CYCLES = `DATA_VALID_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] cfg_one,
    input  wire logic [7:0] cfg_three,
    output logic            init_busy
);
    logic [7:0]  cfg1_q;
    logic [7:0]  cfg3_q;
    logic [31:0] wait_q;
    wire changed = (((cfg_one ^ cfg1_q) & `CFG1_WATCH_MASK) != 8'h00) ||
                   (((cfg_three ^ cfg3_q) & `CFG3_WATCH_MASK) != 8'h00);

    assign init_busy = (wait_q != 32'h0000_0000);

    // [RULE15] Restart on change.
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg1_q <= 8'h00;
            cfg3_q <= 8'h00;
            wait_q <= 32'(VALID_CYCLES);
        end else begin
            cfg1_q <= cfg_one;
            cfg3_q <= cfg_three;
            wait_q <= changed ? 32'(VALID_CYCLES) : (init_busy ? wait_q - 32'h0000_0001 : wait_q);
        end
    end

    a_init_restart: assert property (@(posedge clk) disable iff (reset) // RULE15
        changed |=> init_busy) else $error("Init flag not raised on change.");
endmodule

// ==== recovery_timer.sv ====
// Shared supply recovery countdown with its own tick prescaler.
// Assumes fault inputs are already synchronous to CLK.
`include "device_summary_status_defs.svh"
module recovery_timer #(
    parameter int          TICK_CYCLES = `TICK_CYCLES,
    parameter logic [15:0] RELOAD      = `RECOVERY_TICKS
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        fault_present,
    output logic             expired
);
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [31:0] pre_q;
    wire         tick = (pre_q == 32'(TICK_CYCLES - 1));

    // [RULE6] [RULE20] Reload on fault.
    // [RULE7] Count down on ticks.
    assign count_d = fault_present ? RELOAD :
                     (tick && count_q != 16'h0000) ? count_q - 16'h0001 : count_q;
    assign expired = (count_q == 16'h0000);

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= 16'h0000;
            pre_q   <= 32'h0000_0000;
        end else begin
            count_q <= count_d;
            pre_q   <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
        end
    end

    a_reload_on_fault: assert property (@(posedge clk) disable iff (reset) // RULE6
        fault_present |=> count_q == RELOAD) else $error("Timer not reloaded on fault.");
    a_hold_at_zero: assert property (@(posedge clk) disable iff (reset) // RULE7
        (!fault_present && count_q == 16'h0000) |=> count_q == 16'h0000) else $error("Timer left zero.");
endmodule

// ==== status_host_model.sv ====
// Host controller model: issues status register reads and transmission reports.
// Assumes its tasks are called just after a falling clock edge.
module status_host_model (
    input  wire logic                   clk,
    output device_summary_status_pkg::host_req_s      req
);
    import device_summary_status_pkg::*;

    initial req = '0;

    task automatic read(input logic [7:0] addr);
        req.rd_addr   = addr;
        req.rd_strobe = 1'b1;
        @(negedge clk);
        req.rd_strobe = 1'b0;
        // A released address bus is not left showing the last value.
        req.rd_addr   = ~addr;
    endtask

    task automatic report(input logic sup, input logic rst);
        req.tx_report_supply = sup;
        req.tx_report_reset  = rst;
        req.tx_done          = 1'b1;
        @(negedge clk);
        req.tx_done          = 1'b0;
        req.tx_report_supply = ~sup;
        req.tx_report_reset  = ~rst;
    endtask
endmodule

// ==== tb_device_status_supply_monitor.sv ====
// Self-checking bench for the device status and supply monitor.
// Assumes shortened counts: 4-cycle tick, 3-tick recovery, 20-cycle init.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
`define WAITC(c) for (int n = 0; n < 200 && !(c); n++) @(negedge clk);
module tb_device_status_supply_monitor;
    timeunit 1ns;
    timeprecision 1ns;
    import device_summary_status_pkg::*;

    logic        clk        = 1'b0;
    logic        reset      = 1'b1;
    status_in_s  status_in  = '0;
    supply_mon_s supply_mon = '0;
    logic        test_enter = 1'b0;
    logic        test_exit  = 1'b0;
    logic        sel        = 1'b0;
    iface_e      iface      = IF_DSI3_A;
    logic [7:0]  cfg_one    = 8'h00;
    logic [7:0]  cfg_three  = 8'h00;
    host_req_s   host_req;
    logic [7:0]  rd_data, summary, supply, exp_rd, sup_exp;
    logic [3:0]  exp_sum;
    logic        rd_valid, resp_en, send_err, auto_clr;
    logic [7:0]  exp_q[$];
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    int          j;
    logic [7:0]  c1_tab[5]  = '{8'h04, 8'h05, 8'h05, 8'h05, 8'h85};
    logic [7:0]  c3_tab[5]  = '{8'h00, 8'h00, 8'h02, 8'h06, 8'h06};
    logic [4:0]  init_tab   = 5'h15;
    iface_e      if_tab[8]  = '{IF_DSI3_A, IF_PSI5_A, IF_SPI_A, IF_I2C_A, IF_DSI3_B, IF_PSI5_B, IF_I2C_B, IF_SPI_B};
    logic [7:0]  sel_tab    = 8'h34;

    always #50 clk = ~clk;

    device_status_supply_monitor #(.TICK_CYCLES(4), .RECOVERY(16'h0003), .VALID_CYCLES(20))
    device_status_supply_monitor_i (
        .CLK                     (clk),
        .RESET                   (reset),
        .STATUS_IN               (status_in),
        .SUPPLY_MON              (supply_mon),
        .TEST_MODE_ENTER         (test_enter),
        .TEST_MODE_EXIT          (test_exit),
        .SUPPLY_AUTOCLEAR_SELECT (sel),
        .INTERFACE_TYPE_SELECT   (iface),
        .CHAN_USER_CONFIG_ONE    (cfg_one),
        .CHAN_USER_CONFIG_THREE  (cfg_three),
        .HOST_REQ                (host_req),
        .RD_DATA                 (rd_data),
        .RD_VALID                (rd_valid),
        .RESPONSE_ENABLE         (resp_en),
        .SEND_ERROR_CODE         (send_err),
        .SUMMARY_STATUS          (summary),
        .SUPPLY_STATUS           (supply)
    );

    status_host_model status_host_model_i (
        .clk (clk),
        .req (host_req)
    );

    task automatic summarize();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The expected answer is queued before the request so the watcher never runs ahead.
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        status_host_model_i.read(addr);
        @(negedge clk);
    endtask

    // Read results are taken at the falling edge, where the registered outputs have settled.
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK(rd_data, exp_rd)
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(27103));
        repeat (5) @(negedge clk);
        reset = 1'b0;
        rd(8'h01, 8'h03);
        rd(8'h01, 8'h01);
        repeat (25) @(negedge clk);
        `CHK(summary, 8'h00)
        for (int i = 0; i < 5; i++) begin
            cfg_one   = c1_tab[i];
            cfg_three = c3_tab[i];
            repeat (3) @(negedge clk);
            `CHK(summary[0], init_tab[i])
            repeat (25) @(negedge clk);
        end
        // Sparse random faults so that each channel, link and memory summary flag is seen both set and clear.
        for (int i = 0; i < 12; i++) begin
            status_in = status_in_s'(16'($urandom & $urandom & $urandom));
            exp_sum   = {|status_in.chan_zero_dsp_status, |status_in.chan_one_dsp_status,
                         |status_in.link_fault_status, |status_in.memory_thermal_status};
            repeat (4) @(negedge clk);
            `CHK(summary[7:4], exp_sum)
        end
        status_in  = '0;
        repeat (4) @(negedge clk);
        test_enter = 1'b1;
        @(negedge clk);
        test_enter = 1'b0;
        @(negedge clk);
        rd(8'h01, 8'h04);
        rd(8'h05, 8'h00);
        test_exit  = 1'b1;
        @(negedge clk);
        test_exit  = 1'b0;
        @(negedge clk);
        `CHK(summary[2], 1'b0)
        for (int k = 0; k < 8; k++) begin
            j          = k % 7;
            iface      = if_tab[k];
            sel        = sel_tab[k];
            auto_clr   = (iface inside {IF_PSI5_A, IF_PSI5_B}) || sel;
            sup_exp    = (j > 3) ? (8'h01 << (j + 1)) : (8'h01 << j);
            supply_mon = supply_mon_s'(7'h01 << j);
            repeat (5) @(negedge clk);
            `CHK({supply, summary[3], resp_en}, {sup_exp, 2'b10})
            supply_mon = '0;
            rd(8'h02, sup_exp);
            `CHK(supply, sup_exp)
            if (auto_clr) begin
                `WAITC(supply === 8'h00)
                // The response gate is registered, so it reopens one cycle after the clear.
                @(negedge clk);
                `CHK({supply, resp_en, send_err}, 10'h002)
            end else if (iface inside {IF_I2C_A, IF_I2C_B}) begin
                `WAITC(resp_en === 1'b1)
                rd(8'h02, sup_exp);
                `CHK(supply, 8'h00)
            end else begin
                `WAITC(send_err === 1'b1)
                `CHK({supply, resp_en}, {sup_exp, 1'b1})
                status_host_model_i.report(1'b1, 1'b0);
                @(negedge clk);
                `CHK({supply, send_err}, 9'h000)
            end
        end
        // A second reset in mid-run must raise the reset flag again.
        reset = 1'b1;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        `CHK({summary[1], supply, resp_en}, 10'h201)
        status_host_model_i.report(1'b0, 1'b1);
        @(negedge clk);
        `CHK(summary[1], 1'b0)
        summarize();
    end
endmodule
